// file: swlpc_consts.vh
// constants for the stop/wait low-power controller
// assumes a single 250 MHz system clock and a 32.768 kHz tick
`ifndef SWLPC_CONSTS_VH
`define SWLPC_CONSTS_VH

// ----------------------------------------------------------------
// clock rates and derived divider
// ----------------------------------------------------------------
`define SWLPC_CLK_HZ        250000000
`define SWLPC_OSC_HZ        32768
`define SWLPC_OSC_DIV       (`SWLPC_CLK_HZ / `SWLPC_OSC_HZ)

// ----------------------------------------------------------------
// wake settling delays, in oscillator cycles
// ----------------------------------------------------------------
`define SWLPC_SETTLE_SHORT  12'd16
`define SWLPC_SETTLE_LONG   12'd4064

// ----------------------------------------------------------------
// controller states
// ----------------------------------------------------------------
`define SWLPC_ST_RUN        2'h0
`define SWLPC_ST_STOP       2'h1
`define SWLPC_ST_WAIT       2'h2
`define SWLPC_ST_SETTLE     2'h3

// ----------------------------------------------------------------
// wake vector selects
// ----------------------------------------------------------------
`define SWLPC_VEC_NONE      3'h0
`define SWLPC_VEC_RESET     3'h1
`define SWLPC_VEC_IRQ       3'h2
`define SWLPC_VEC_INT_A     3'h3
`define SWLPC_VEC_INT_B     3'h4
`define SWLPC_VEC_RTC       3'h5
`define SWLPC_VEC_TIMER     3'h6
`define SWLPC_VEC_SPI       3'h7

// ----------------------------------------------------------------
// timer load value after a reset wake
// ----------------------------------------------------------------
`define SWLPC_TIMER_RST_VAL 16'hfffc

`endif

// file: swlpc_osc_div.v
// divider that makes the one-cycle oscillator tick from clock_in
// assumes clock_in is the only clock; enable_in models the oscillator
module swlpc_osc_div #(
   parameter DIV = 7629
) (
   input  wire clock_in,
   input  wire rst_in,
   input  wire enable_in,
   output reg  tick_out
);
   reg [15:0] count_reg;

   // a stopped oscillator restarts its phase from zero
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg <= 16'h0000;
         tick_out  <= 1'b0;
      end else if (!enable_in) begin
         count_reg <= 16'h0000;
         tick_out  <= 1'b0;
      end else if (count_reg == DIV[15:0] - 16'h0001) begin
         count_reg <= 16'h0000;
         tick_out  <= 1'b1;
      end else begin
         count_reg <= count_reg + 16'h0001;
         tick_out  <= 1'b0;
      end
   end
endmodule // swlpc_osc_div

// file: swlpc_ctrl.v
// stop/wait low-power controller: clock gating, wake, settle, vectors
// assumes the cpu core issues one-cycle stop/wait request pulses and
// that all inputs are synchronous to clock_in
// the settle counter runs on the divided oscillator tick, so the first
// tick period after a wake with the oscillator running is partial and the delay is short by up to
// one tick; every output leaves a flip-flop one cycle after its cause
`include "swlpc_consts.vh"

module swlpc_ctrl #(
   parameter OSC_DIV = `SWLPC_OSC_DIV
) (
   input  wire        clock_in,
   input  wire        rst_in,
   input  wire        stop_req_in,
   input  wire        wait_req_in,
   input  wire        osc_off_in_stop_in,
   input  wire        ext_reset_in,
   input  wire        ext_irq_in,
   input  wire        ext_int_a_in,
   input  wire        ext_int_b_in,
   input  wire        rtc_irq_in,
   input  wire        timer_irq_in,
   input  wire        spi_irq_in,
   input  wire        capture_edge_in,
   input  wire        spi_slave_in,
   input  wire        spi_slave_done_in,
   input  wire        rtc_enable_in,
   input  wire        timer_enable_in,
   input  wire        spi_enable_in,
   input  wire        drivers_en_in,
   output reg  [1:0]  state_out,
   output reg         cpu_clk_en_out,
   output reg         cpu_halt_out,
   output reg         int_mask_clr_out,
   output reg         io_hold_out,
   output reg         osc_en_out,
   output reg         rtc_run_out,
   output reg         timer_run_out,
   output reg         timer_load_out,
   output reg  [15:0] timer_load_value_out,
   output reg         capture_post_out,
   output reg         spi_brg_en_out,
   output reg         spi_slave_run_out,
   output reg         spi_protect_en_out,
   output reg         spi_flag_post_out,
   output reg         spi_reset_out,
   output reg         sys_reset_out,
   output reg         drivers_en_out,
   output reg         vector_load_out,
   output reg  [2:0]  vector_sel_out
);

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   localparam [1:0] st_run    = 2'h0;
   localparam [1:0] st_stop   = 2'h1;
   localparam [1:0] st_wait   = 2'h2;
   localparam [1:0] st_settle = 2'h3;

   // ----------------------------------------------------------------
   // state and working registers
   // ----------------------------------------------------------------
   reg [1:0]  state_reg;
   reg [1:0]  state_next;
   reg [11:0] settle_reg;
   reg [11:0] settle_next;
   reg [2:0]  vec_reg;
   reg [2:0]  vec_next;
   reg        osc_on_reg;
   reg        osc_on_next;
   reg        cap_armed_reg;
   reg        cap_armed_next;
   reg        spi_pend_reg;
   reg        spi_pend_next;
   reg        from_stop_reg;
   reg        from_stop_next;
   reg        wake_stop;
   reg        wake_wait;
   reg [2:0]  src_sel;
   reg        ext_int_any;
   wire       osc_tick;

   // ----------------------------------------------------------------
   // oscillator tick
   // ----------------------------------------------------------------
   swlpc_osc_div #(
      .DIV       (OSC_DIV)
   ) u_osc_div (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .enable_in (osc_on_reg),
      .tick_out  (osc_tick)
   );

   // ----------------------------------------------------------------
   // wake source decode, highest priority first
   // ----------------------------------------------------------------
   always @* begin
      ext_int_any = ext_irq_in | ext_int_a_in | ext_int_b_in;
      if (ext_reset_in) begin
         src_sel = `SWLPC_VEC_RESET;
      end else if (ext_irq_in) begin
         src_sel = `SWLPC_VEC_IRQ;
      end else if (ext_int_a_in) begin
         src_sel = `SWLPC_VEC_INT_A;
      end else if (ext_int_b_in) begin
         src_sel = `SWLPC_VEC_INT_B;
      end else if (rtc_irq_in) begin
         src_sel = `SWLPC_VEC_RTC;
      end else if (timer_irq_in) begin
         src_sel = `SWLPC_VEC_TIMER;
      end else if (spi_irq_in) begin
         src_sel = `SWLPC_VEC_SPI;
      end else begin
         src_sel = `SWLPC_VEC_NONE;
      end
      // timer and spi interrupts cannot wake stop
      wake_stop = ext_reset_in | ext_int_any | rtc_irq_in;
      wake_wait = wake_stop | timer_irq_in | spi_irq_in;
   end

   // ----------------------------------------------------------------
   // request and event qualifiers
   // ----------------------------------------------------------------
   // requests count only in run; a reset in the same cycle beats them,
   // and stop beats wait when the core raises both
   wire take_stop     = (state_reg == st_run) && stop_req_in &&
                        !ext_reset_in;
   wire take_wait     = (state_reg == st_run) && wait_req_in &&
                        !stop_req_in && !ext_reset_in;
   // a slave transfer that ends while stopped only raises a pending
   // flag; the flag itself is posted after an external interrupt wake
   wire slv_done_stop = (state_reg == st_stop) && spi_slave_in &&
                        spi_slave_done_in;
   // a stopped crystal or a reset pays the full start-up time
   wire need_long     = ext_reset_in || !osc_on_reg;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always @* begin
      state_next     = state_reg;
      settle_next    = settle_reg;
      vec_next       = vec_reg;
      osc_on_next    = osc_on_reg;
      cap_armed_next = cap_armed_reg;
      spi_pend_next  = spi_pend_reg;
      from_stop_next = from_stop_reg;
      case (state_reg)
         st_run: begin
            // a reset in run pays the long settle; the oscillator stays running
            if (ext_reset_in) begin
               state_next     = st_settle;
               settle_next    = `SWLPC_SETTLE_LONG;
               vec_next       = `SWLPC_VEC_RESET;
               osc_on_next    = 1'b1;
               from_stop_next = 1'b0;
            end else if (take_stop) begin
               state_next  = st_stop;
               osc_on_next = ~osc_off_in_stop_in;
            end else if (take_wait) begin
               // the core should never raise both; stop wins if it does
               state_next = st_wait;
            end
         end
         st_stop: begin
            if (capture_edge_in) begin
               cap_armed_next = 1'b1;
            end
            if (slv_done_stop) begin
               spi_pend_next = 1'b1;
            end
            // timer and spi interrupts are not part of wake_stop
            if (wake_stop) begin
               state_next     = st_settle;
               vec_next       = src_sel;
               from_stop_next = 1'b1;
               osc_on_next    = 1'b1;
               if (need_long) begin
                  settle_next = `SWLPC_SETTLE_LONG;
               end else begin
                  settle_next = `SWLPC_SETTLE_SHORT;
               end
            end
         end
         st_wait: begin
            // wait keeps clocks up, so no settling is needed
            if (wake_wait) begin
               state_next     = st_settle;
               vec_next       = src_sel;
               settle_next    = 12'd0;
               from_stop_next = 1'b0;
            end
         end
         st_settle: begin
            if (settle_reg == 12'd0) begin
               state_next = st_run;
               // an armed capture is posted or, on a reset wake, dropped
               cap_armed_next = 1'b0;
            end else if (osc_tick) begin
               settle_next = settle_reg - 12'd1;
            end
            // a later reset during settle still forces the long delay
            if (ext_reset_in && vec_reg != `SWLPC_VEC_RESET) begin
               state_next  = st_settle;
               vec_next    = `SWLPC_VEC_RESET;
               settle_next = `SWLPC_SETTLE_LONG;
            end
         end
         default: begin
            state_next = st_run;
         end
      endcase
      // pending slave flags are posted only on an external interrupt, the
      // waking one included, which is still seen in the stop cycle
      if (state_next != st_stop && ext_int_any) begin
         spi_pend_next = 1'b0;
      end
      // a reset wake drops them without posting
      if (state_next == st_settle &&
          vec_next == `SWLPC_VEC_RESET) begin
         spi_pend_next = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg     <= st_run;
         settle_reg    <= 12'd0;
         vec_reg       <= `SWLPC_VEC_NONE;
         osc_on_reg    <= 1'b1;
         cap_armed_reg <= 1'b0;
         spi_pend_reg  <= 1'b0;
         from_stop_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         settle_reg    <= settle_next;
         vec_reg       <= vec_next;
         osc_on_reg    <= osc_on_next;
         cap_armed_reg <= cap_armed_next;
         spi_pend_reg  <= spi_pend_next;
         from_stop_reg <= from_stop_next;
      end
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   // the resume pulse fires on the cycle settle leaves for run
   wire resume     = (state_reg == st_settle) &&
                     (state_next == st_run);
   wire resume_rst = resume && (vec_reg == `SWLPC_VEC_RESET);
   wire in_stop    = (state_next == st_stop);
   wire in_wait    = (state_next == st_wait);
   wire in_settle  = (state_next == st_settle);

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_out            <= st_run;
         cpu_clk_en_out       <= 1'b1;
         cpu_halt_out         <= 1'b0;
         int_mask_clr_out     <= 1'b0;
         io_hold_out          <= 1'b0;
         osc_en_out           <= 1'b1;
         rtc_run_out          <= 1'b0;
         timer_run_out        <= 1'b0;
         timer_load_out       <= 1'b0;
         timer_load_value_out <= `SWLPC_TIMER_RST_VAL;
         capture_post_out     <= 1'b0;
         spi_brg_en_out       <= 1'b0;
         spi_slave_run_out    <= 1'b0;
         spi_protect_en_out   <= 1'b1;
         spi_flag_post_out    <= 1'b0;
         spi_reset_out        <= 1'b0;
         sys_reset_out        <= 1'b0;
         drivers_en_out       <= 1'b0;
         vector_load_out      <= 1'b0;
         vector_sel_out       <= `SWLPC_VEC_NONE;
      end else begin
         state_out <= state_next;
         // processor clock off in stop and in settle
         cpu_clk_en_out <= ~(in_stop | in_settle);
         cpu_halt_out   <= in_stop | in_wait | in_settle;
         // mask clears on the entry edge only
         int_mask_clr_out <= take_stop | take_wait;
         // cpu registers, memory and port latches freeze
         io_hold_out <= in_stop | in_wait;
         osc_en_out  <= osc_on_next;
         // rtc cannot be turned off while waiting
         rtc_run_out <= osc_on_next &
                        (rtc_enable_in | in_wait) &
                        ~(in_settle & from_stop_next);
         // timer is frozen with the processor clock
         timer_run_out  <= timer_enable_in & ~in_stop & ~in_settle;
         timer_load_out <= resume_rst & from_stop_reg;
         capture_post_out <= resume & ~resume_rst &
                             cap_armed_reg;
         // master transfers pause with the baud generator
         spi_brg_en_out <= spi_enable_in & ~in_stop & ~in_settle;
         spi_slave_run_out <= spi_enable_in & spi_slave_in;
         // slave has no collision or fault checks while stopped
         spi_protect_en_out <= ~in_stop;
         // a completion in the waking cycle is posted with the rest
         spi_flag_post_out  <= (spi_pend_reg | slv_done_stop) &
                               ~spi_pend_next &
                               ~(in_settle &
                                 (vec_next == `SWLPC_VEC_RESET));
         spi_reset_out   <= resume_rst;
         sys_reset_out   <= resume_rst;
         drivers_en_out  <= drivers_en_in;
         vector_load_out <= resume;
         if (resume) begin
            vector_sel_out <= vec_reg;
         end
      end
   end

endmodule // swlpc_ctrl

// file: swlpc_props.sv
// assertions for the low-power controller, bound to swlpc_ctrl
// assumes one clock domain and an oscillator tick every OSC_DIV cycles
`include "swlpc_consts.vh"
module swlpc_props #(
   parameter OSC_DIV = 4
) (
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       stop_req_in,
   input wire logic       ext_reset_in,
   input wire logic       ext_irq_in,
   input wire logic       ext_int_a_in,
   input wire logic       ext_int_b_in,
   input wire logic       rtc_irq_in,
   input wire logic [1:0] state_out,
   input wire logic       cpu_clk_en_out,
   input wire logic       int_mask_clr_out,
   input wire logic       io_hold_out,
   input wire logic       osc_en_out,
   input wire logic       spi_brg_en_out,
   input wire logic       spi_protect_en_out,
   input wire logic       spi_reset_out,
   input wire logic       sys_reset_out,
   input wire logic       capture_post_out,
   input wire logic       vector_load_out,
   input wire logic [2:0] vector_sel_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] st_stop = `SWLPC_ST_STOP;
   localparam logic [1:0] st_wait = `SWLPC_ST_WAIT;
   localparam int sh_lo = 15 * OSC_DIV;
   localparam int sh_hi = 16 * OSC_DIV + 3;
   localparam int lg_lo = 4063 * OSC_DIV;
   localparam int lg_hi = 4064 * OSC_DIV + 3;
   wire         wake = ext_reset_in | ext_irq_in | ext_int_a_in |
                       ext_int_b_in | rtc_irq_in;
   wire         rvec = vector_sel_out == `SWLPC_VEC_RESET;
   logic [15:0] cnt_reg;
   logic        stop_reg;
   logic        off_reg;
   // settle length is held through the resume cycle so it can be judged
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg  <= 16'h0;
         stop_reg <= 1'b0;
         off_reg  <= 1'b0;
      end else begin
         cnt_reg <= (state_out == `SWLPC_ST_SETTLE) ? cnt_reg + 16'h1 :
                    vector_load_out ? cnt_reg : 16'h0;
         if (state_out == st_stop || state_out == st_wait) begin
            stop_reg <= state_out == st_stop;
            off_reg  <= !osc_en_out;
         end
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   a_clk_off: assert property (
      state_out == st_stop |-> !cpu_clk_en_out) else $error("clock on");
   a_stop_entry: assert property (
      state_out == 2'h0 && stop_req_in && !ext_reset_in |=>
      state_out == st_stop && int_mask_clr_out) else $error("no stop");
   a_hold_io: assert property (
      state_out == st_stop || state_out == st_wait |-> io_hold_out)
      else $error("io not held");
   a_stop_stays: assert property (
      state_out == st_stop && !wake |=> state_out == st_stop)
      else $error("stray wake");
   a_short_settle: assert property (
      vector_load_out && stop_reg && !off_reg && !rvec |->
      cnt_reg >= sh_lo && cnt_reg <= sh_hi) else $error("short settle");
   a_long_settle: assert property (
      vector_load_out && stop_reg && (off_reg || rvec) |->
      cnt_reg >= lg_lo && cnt_reg <= lg_hi) else $error("long settle");
   a_reset_resume: assert property (
      vector_load_out && rvec |-> sys_reset_out && spi_reset_out &&
      !capture_post_out) else $error("reset resume");
   a_spi_in_stop: assert property (
      state_out == st_stop |-> !spi_brg_en_out && !spi_protect_en_out)
      else $error("spi active");
   cover property (vector_load_out && rvec);
   cover property (state_out == st_wait ##1 !io_hold_out);
   cover property (state_out == st_stop && !osc_en_out);
endmodule // swlpc_props

bind swlpc_ctrl swlpc_props #(.OSC_DIV(OSC_DIV)) u_swlpc_props (.*);

// file: swlpc_cpu_model.sv
// cpu side: turns bench commands into stop and wait request pulses
// assumes each command is held for exactly one clock
module swlpc_cpu_model (
   input  wire logic clock_in,
   input  wire logic rst_in,
   input  wire logic do_stop_in,
   input  wire logic do_wait_in,
   output logic      stop_req_out,
   output logic      wait_req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // one pulse per decoded instruction, before the mask update
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         stop_req_out <= 1'b0;
         wait_req_out <= 1'b0;
      end else begin
         stop_req_out <= do_stop_in;
         wait_req_out <= do_wait_in;
      end
   end
endmodule // swlpc_cpu_model

// file: tb_stop_wait_low_power_control.sv
// bench for the stop/wait low-power controller and its cpu model
// assumes OSC_DIV shortened to 4; a long settle takes some 16k cycles
`include "swlpc_consts.vh"
module tb_stop_wait_low_power_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, go_s, go_w, osc_off, cap, sdone, rtc_en, t_en;
   logic       s_en, drv, clr, slv, pend;
   logic [6:0] src;
   logic [4:0] seen;
   wire        sreq, wreq, clk_en, hold, osc_en, rtc_run, tload, cpost;
   wire        srun, fpost, sprst, sysrst, drv_o, vload, halt, trun;
   wire [1:0]  st;
   wire [2:0]  vsel;
   wire [15:0] tval;
   int         seed, mismatches, n_checks, k, i;
   swlpc_cpu_model u_swlpc_cpu_model (.clock_in(clk), .rst_in(rst),
      .do_stop_in(go_s), .do_wait_in(go_w), .stop_req_out(sreq),
      .wait_req_out(wreq));
   swlpc_ctrl #(.OSC_DIV(4)) u_swlpc_ctrl (.clock_in(clk), .rst_in(rst),
      .stop_req_in(sreq), .wait_req_in(wreq), .osc_off_in_stop_in(osc_off),
      .ext_reset_in(src[0]), .ext_irq_in(src[1]), .ext_int_a_in(src[2]),
      .ext_int_b_in(src[3]), .rtc_irq_in(src[4]), .timer_irq_in(src[5]),
      .spi_irq_in(src[6]), .capture_edge_in(cap), .spi_slave_in(slv),
      .spi_slave_done_in(sdone), .rtc_enable_in(rtc_en),
      .timer_enable_in(t_en), .spi_enable_in(s_en), .drivers_en_in(drv),
      .state_out(st), .cpu_clk_en_out(clk_en), .cpu_halt_out(halt),
      .int_mask_clr_out(), .io_hold_out(hold), .osc_en_out(osc_en),
      .rtc_run_out(rtc_run), .timer_run_out(trun), .timer_load_out(tload),
      .timer_load_value_out(tval), .capture_post_out(cpost),
      .spi_brg_en_out(), .spi_slave_run_out(srun),
      .spi_protect_en_out(), .spi_flag_post_out(fpost),
      .spi_reset_out(sprst), .sys_reset_out(sysrst),
      .drivers_en_out(drv_o), .vector_load_out(vload),
      .vector_sel_out(vsel));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // pulses are one cycle wide, so they are gathered here between checks
   always @(posedge clk)
      seen <= clr ? 5'h0 : seen | {sysrst, sprst, tload, fpost, cpost};
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [2:0] vec_of(input int s);
      return 3'(s + 1);
   endfunction
   task automatic enter(input logic w);
      @(posedge clk);
      go_s <= !w;
      go_w <= w;
      @(posedge clk);
      go_s <= 1'b0;
      go_w <= 1'b0;
      k = 0;
      do @(negedge clk); while (st === 2'h0 && ++k < 20);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      @(negedge clk);
   endtask
   // a source is shown for one edge only; a reset held longer does not restart the settle
   task automatic wake(input int s, output logic [2:0] v);
      @(posedge clk);
      src <= 7'h1 << s;
      @(posedge clk);
      src <= 7'h0;
      k = 0;
      do @(negedge clk); while (vload !== 1'b1 && ++k < 20000);
      v = vsel;
      repeat (2) @(negedge clk);
   endtask
   task automatic stop_op(input int s, input logic off, input logic ce);
      logic [2:0] v;
      @(posedge clk);
      osc_off <= off;
      slv <= 1'($random(seed));
      drv <= 1'($random(seed));
      enter(1'b0);
      chk(clk_en, 1'b0);
      chk(halt, 1'b1);
      chk(trun, 1'b0);
      chk(hold, 1'b1);
      chk(drv_o, drv);
      chk({osc_en, rtc_run}, {2{!off}});
      chk(srun, slv);
      @(posedge clk);
      src <= 7'h60;
      cap <= ce;
      sdone <= 1'b1;
      @(posedge clk);
      src <= 7'h0;
      cap <= 1'b0;
      sdone <= 1'b0;
      // a slave completion stays pending until an external wake
      pend = pend | slv;
      repeat (3) @(negedge clk);
      chk(st, `SWLPC_ST_STOP);
      wake(s, v);
      chk(v, vec_of(s));
      chk(seen[0], ce && s != 0);
      chk(seen[1], pend && s != 0 && s != 4);
      chk(seen[4:2], {3{s == 0}});
      pend = pend && s == 4;
   endtask
   task automatic wait_op(input int s);
      logic [2:0] v;
      @(posedge clk);
      rtc_en <= 1'b0;
      t_en <= 1'($random(seed));
      s_en <= 1'($random(seed));
      enter(1'b1);
      chk({st, clk_en, hold}, {`SWLPC_ST_WAIT, 2'h3});
      chk({halt, trun}, {1'b1, t_en});
      chk(rtc_run, 1'b1);
      wake(s, v);
      chk(v, vec_of(s));
      chk(seen[4], 1'b0);
      chk(rtc_run, 1'b0);
      @(posedge clk);
      rtc_en <= 1'b1;
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      seed = 3471;
      {go_s, go_w, osc_off, cap, sdone, drv, src, slv, pend} = '0;
      clr = 1'b1;
      {rtc_en, t_en, s_en} = 3'h7;
      rst = 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(tval, `SWLPC_TIMER_RST_VAL);
      for (i = 0; i < 8; i++)
         stop_op(1 + ($unsigned($random(seed)) % 4), 1'b0, 1'($random(seed)));
      stop_op(0, 1'b0, 1'b1);
      stop_op(1, 1'b1, 1'b0);
      for (i = 4; i < 7; i++)
         wait_op(i);
      tally_and_finish;
   end
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      tally_and_finish;
   end
endmodule // tb_stop_wait_low_power_control
